// file: verilog/pin_mux_pkg.sv
/*
   Constants shared by the pin function multiplexer: pin count, peripheral
   code width and the reset image of every configuration register.
   Assumes pins are numbered port A bits 0..7, port B 8..15, port C 16..23.
*/
package pin_mux_pkg;

   // ----------------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------------
   localparam int DEF_PINS  = 24;                 // Pins served by default
   localparam int CODE_W    = 4;                  // Peripheral code field width
   localparam int NUM_CODES = 16;                 // Codes per pin, 0 is none

   // ----------------------------------------------------------------------
   // Reset images, pin 0 in bit 0 / low nibble
   // ----------------------------------------------------------------------
   localparam logic [DEF_PINS-1:0]        AFSEL_RST = 24'h0f0000;  // Debug pins on port C
   localparam logic [DEF_PINS-1:0]        DEN_RST   = 24'h0f0000;  // Debug pins stay digital
   localparam logic [DEF_PINS-1:0]        ANALOG_SELECT_BIT_RST = 24'h000000;  // No analog isolation
   localparam logic [DEF_PINS*CODE_W-1:0] PCTL_RST  = 96'h0000_3333_0000_1100_0011_1111; // Default codes

endpackage

// file: verilog/pin_route_cell.sv
/*
   One pin of the function multiplexer: input synchroniser, routing of the
   pad to GPIO, to one peripheral slot or to an analog path, all registered.
   Assumes configuration inputs come from registers on the same clock.
*/
`timescale 1ns/1ps
module pin_route_cell
   import pin_mux_pkg::*;
#(
   parameter int NC = NUM_CODES                   // Peripheral slots per pin
) (
   input  wire logic              clk_sys_i,      // System clock
   input  wire logic              reset_i,        // Synchronous reset, high
   input  wire logic              afsel_i,        // Alternate function select
   input  wire logic              den_i,          // Digital enable
   input  wire logic              analog_select_bit_i,        // Analog mode select
   input  wire logic [CODE_W-1:0] code_i,         // Peripheral mux code
   input  wire logic              gpio_out_i,     // GPIO output data
   input  wire logic              gpio_oe_i,      // GPIO direction, 1 drives
   input  wire logic [NC-1:0]     periph_out_i,   // Peripheral output per slot
   input  wire logic [NC-1:0]     periph_oe_i,    // Peripheral enable per slot
   input  wire logic              pad_in_i,       // Pad level from outside
   output logic                   pad_out_o,      // Level to drive on pad
   output logic                   pad_oe_o,       // High while pad is driven
   output logic                   gpio_in_o,      // Pad level to GPIO logic
   output logic [NC-1:0]          periph_in_o,    // Pad level to chosen slot
   output logic                   iso_en_o,       // Isolated analog path on
   output logic                   direct_an_o     // Direct analog path on
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   logic          s1_r, s2_r, s3_r, pin_val_r;              // Synchroniser
   logic          s1_nxt, s2_nxt, s3_nxt, pin_val_nxt;
   logic          pad_out_nxt, pad_oe_nxt, gpio_in_nxt;      // Routed outputs
   logic [NC-1:0] periph_in_nxt;
   logic          iso_nxt, direct_nxt;
   logic          alt_on;                                     // Alternate active

   // ----------------------------------------------------------------------
   // Next values
   // ----------------------------------------------------------------------
   // Routing decision and synchroniser advance
   always_comb begin
      s1_nxt        = pad_in_i;
      s2_nxt        = s1_r;
      s3_nxt        = s2_r;
      // Level accepted only once the two settled stages agree
      pin_val_nxt   = (s2_r == s3_r) ? s3_r : pin_val_r;
      alt_on        = afsel_i && den_i;
      pad_out_nxt   = 1'b0;
      pad_oe_nxt    = 1'b0;
      periph_in_nxt = '0;
      if (alt_on) begin
         // Code 0 names no peripheral, so the pad is left undriven
         if (code_i != '0) begin
            pad_out_nxt           = periph_out_i[code_i];
            pad_oe_nxt            = periph_oe_i[code_i];
            periph_in_nxt[code_i] = pin_val_r;
         end
      end else if (den_i) begin
         // Plain GPIO, code field ignored
         pad_out_nxt = gpio_out_i;
         pad_oe_nxt  = gpio_oe_i;
      end
      gpio_in_nxt = den_i ? pin_val_r : 1'b0;
      iso_nxt     = !den_i && analog_select_bit_i;
      direct_nxt  = !den_i && !analog_select_bit_i;
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         s1_r        <= 1'b0;
         s2_r        <= 1'b0;
         s3_r        <= 1'b0;
         pin_val_r   <= 1'b0;
         pad_out_o   <= 1'b0;
         pad_oe_o    <= 1'b0;
         gpio_in_o   <= 1'b0;
         periph_in_o <= '0;
         iso_en_o    <= 1'b0;
         direct_an_o <= 1'b0;
      end else begin
         s1_r        <= s1_nxt;
         s2_r        <= s2_nxt;
         s3_r        <= s3_nxt;
         pin_val_r   <= pin_val_nxt;
         pad_out_o   <= pad_out_nxt;
         pad_oe_o    <= pad_oe_nxt;
         gpio_in_o   <= gpio_in_nxt;
         periph_in_o <= periph_in_nxt;
         iso_en_o    <= iso_nxt;
         direct_an_o <= direct_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   sequence alt_on_s;
      afsel_i && den_i && (code_i != '0);
   endsequence

   sequence gpio_on_s;
      !afsel_i && den_i;
   endsequence

   alt_route_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      alt_on_s |=> (pad_oe_o == $past(periph_oe_i[code_i])) && (pad_out_o == $past(periph_out_i[code_i])))
      else $error("Active alternate pin does not follow its peripheral");

   alt_block_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      !(afsel_i && den_i) |=> (periph_in_o == '0))
      else $error("Peripheral sees a pin whose alternate is off");

   code_select_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      alt_on_s |=> (periph_in_o == ((NC'(1) << $past(code_i)) & {NC{$past(pin_val_r)}})))
      else $error("Pin input reaches the wrong peripheral slot");

   gpio_route_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      gpio_on_s |=> (pad_out_o == $past(gpio_out_i)) && (pad_oe_o == $past(gpio_oe_i)))
      else $error("GPIO pin does not follow GPIO data and direction");

   iso_path_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (!den_i && analog_select_bit_i) |=> iso_en_o && !pad_oe_o && !direct_an_o)
      else $error("Isolated analog path not selected");

   direct_path_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (!den_i && !analog_select_bit_i) |=> direct_an_o && !pad_oe_o && !iso_en_o && !gpio_in_o)
      else $error("Direct analog pin still digital");

endmodule

// file: verilog/pin_function_mux.sv
/*
   Pin function multiplexer: holds per-pin alternate select, digital enable,
   analog mode and peripheral code, and routes every pin through one cell.
   Assumes write strobes are one-cycle pulses on the system clock and that
   pad inputs are asynchronous to it.
*/
// Summary of operation
// - Pins reset to direct analog except debug pins
// - Any reset restores all pin configuration
// - Alternate needs select and digital enable
// - Code field picks the connected peripheral
// - Default code 0x1 on pins 0-5, 10, 11; debug pins select 0x3
// - Digital off, analog on: isolated path
// - Digital off alone: direct analog path
`timescale 1ns/1ps
module pin_function_mux
   import pin_mux_pkg::*;
#(
   parameter int NUM_PINS = DEF_PINS,             // Pins served
   parameter int NC       = NUM_CODES             // Peripheral slots per pin
) (
   input  wire logic                       clk_sys_i,     // System clock, 20 MHz
   input  wire logic                       reset_i,       // Power-on or pin reset, high
   input  wire logic                       afsel_wr_i,    // Write alternate select
   input  wire logic [NUM_PINS-1:0]        afsel_wdata_i, // New alternate select
   input  wire logic                       den_wr_i,      // Write digital enable
   input  wire logic [NUM_PINS-1:0]        den_wdata_i,   // New digital enable
   input  wire logic                       analog_select_bit_wr_i,    // Write analog mode
   input  wire logic [NUM_PINS-1:0]        analog_select_bit_wdata_i, // New analog mode
   input  wire logic                       pctl_wr_i,     // Write code field
   input  wire logic [NUM_PINS*CODE_W-1:0] pctl_wdata_i,  // New codes
   input  wire logic [NUM_PINS-1:0]        gpio_out_i,    // GPIO output data
   input  wire logic [NUM_PINS-1:0]        gpio_oe_i,     // GPIO direction
   input  wire logic [NUM_PINS*NC-1:0]     periph_out_i,  // Peripheral outputs
   input  wire logic [NUM_PINS*NC-1:0]     periph_oe_i,   // Peripheral enables
   input  wire logic [NUM_PINS-1:0]        pad_in_i,      // Pad levels
   output logic [NUM_PINS-1:0]             pad_out_o,     // Pad drive levels
   output logic [NUM_PINS-1:0]             pad_oe_o,      // Pad drive enables
   output logic [NUM_PINS-1:0]             gpio_in_o,     // Pad levels to GPIO
   output logic [NUM_PINS*NC-1:0]          periph_in_o,   // Pad levels to slots
   output logic [NUM_PINS-1:0]             iso_en_o,      // Isolated analog on
   output logic [NUM_PINS-1:0]             direct_an_o,   // Direct analog on
   output logic [NUM_PINS-1:0]             afsel_o,       // alternate_function_select_reg
   output logic [NUM_PINS-1:0]             den_o,         // digital_enable_reg
   output logic [NUM_PINS-1:0]             analog_select_bit_o,       // analog_mode_select_reg
   output logic [NUM_PINS*CODE_W-1:0]      pctl_o         // port_control_mux_reg
);

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   // Reset images are laid out for exactly the default pin count
   if (NUM_PINS != DEF_PINS) begin : g_bad_pins
      $error("NUM_PINS must equal the default pin count");
   end
   if (NC != (1 << CODE_W)) begin : g_bad_slots
      $error("NC must cover every code of the field");
   end

   // ----------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------
   logic [NUM_PINS-1:0]        afsel_nxt;         // Next alternate select
   logic [NUM_PINS-1:0]        den_nxt;           // Next digital enable
   logic [NUM_PINS-1:0]        analog_select_bit_nxt;         // Next analog mode
   logic [NUM_PINS*CODE_W-1:0] pctl_nxt;          // Next code field

   // Each register loads on its own strobe, else holds
   always_comb begin
      afsel_nxt = afsel_wr_i ? afsel_wdata_i : afsel_o;
      den_nxt   = den_wr_i   ? den_wdata_i   : den_o;
      analog_select_bit_nxt = analog_select_bit_wr_i ? analog_select_bit_wdata_i : analog_select_bit_o;
      pctl_nxt  = pctl_wr_i  ? pctl_wdata_i  : pctl_o;
   end

   // Reset returns all pins to their default assignment
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         afsel_o <= AFSEL_RST;
         den_o   <= DEN_RST;
         analog_select_bit_o <= ANALOG_SELECT_BIT_RST;
         pctl_o  <= PCTL_RST;
      end else begin
         afsel_o <= afsel_nxt;
         den_o   <= den_nxt;
         analog_select_bit_o <= analog_select_bit_nxt;
         pctl_o  <= pctl_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Per-pin routing
   // ----------------------------------------------------------------------
   for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      pin_route_cell #(
         .NC           (NC)
      ) u_cell (
         .clk_sys_i    (clk_sys_i),
         .reset_i      (reset_i),
         .afsel_i      (afsel_o[p]),
         .den_i        (den_o[p]),
         .analog_select_bit_i      (analog_select_bit_o[p]),
         .code_i       (pctl_o[p*CODE_W +: CODE_W]),
         .gpio_out_i   (gpio_out_i[p]),
         .gpio_oe_i    (gpio_oe_i[p]),
         .periph_out_i (periph_out_i[p*NC +: NC]),
         .periph_oe_i  (periph_oe_i[p*NC +: NC]),
         .pad_in_i     (pad_in_i[p]),
         .pad_out_o    (pad_out_o[p]),
         .pad_oe_o     (pad_oe_o[p]),
         .gpio_in_o    (gpio_in_o[p]),
         .periph_in_o  (periph_in_o[p*NC +: NC]),
         .iso_en_o     (iso_en_o[p]),
         .direct_an_o  (direct_an_o[p])
      );
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   sequence quiet_reset_s;
      reset_i && !afsel_wr_i && !den_wr_i && !analog_select_bit_wr_i && !pctl_wr_i;
   endsequence

   reset_default_a: assert property (@(posedge clk_sys_i)
      reset_i |=> (afsel_o == AFSEL_RST) && (pctl_o == PCTL_RST) && (den_o == DEN_RST))
      else $error("Reset did not restore pin defaults");

   reset_codes_a: assert property (@(posedge clk_sys_i)
      quiet_reset_s |=> (pctl_o[16*CODE_W +: 4*CODE_W] == 16'h3333) && (afsel_o[19:16] == 4'hf)
                        && (pctl_o[3:0] == 4'h1) && (afsel_o[5:0] == 6'h00))
      else $error("Default code or select wrong after reset");

   reset_gpio_a: assert property (@(posedge clk_sys_i)
      reset_i ##1 !reset_i |=> ((afsel_o & ~AFSEL_RST) == '0) || $past(afsel_wr_i))
      else $error("Non-default pin left in alternate mode after reset");

   write_load_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      pctl_wr_i |=> (pctl_o == $past(pctl_wdata_i)))
      else $error("Code field write not taken");

endmodule

// file: verif/pin_function_mux_test.sv
/*
   Self-checking bench for the pin function multiplexer: reset images,
   alternate, GPIO and analog routing, pad input delivery, mid-run reset.
   Assumes the package geometry of 24 pins and 16 peripheral slots per pin.
*/
`timescale 1ns/1ps
module pin_function_mux_test
   import pin_mux_pkg::*;
;
   // ----------------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------------
   localparam int NS = DEF_PINS*NUM_CODES;        // Slot vector width
   logic                       clk_sys_i;         // System clock
   logic                       reset_i;           // Synchronous reset
   logic                       afsel_wr_i, den_wr_i, analog_select_bit_wr_i, pctl_wr_i;  // Write strobes
   logic [DEF_PINS-1:0]        afsel_wdata_i, den_wdata_i, analog_select_bit_wdata_i;   // Write data
   logic [DEF_PINS*CODE_W-1:0] pctl_wdata_i;      // Code write data
   logic [DEF_PINS-1:0]        gpio_out_i, gpio_oe_i, pad_in_i;             // GPIO and pads
   logic [NS-1:0]              periph_out_i, periph_oe_i;                   // Peripheral side
   logic [DEF_PINS-1:0]        pad_out_o, pad_oe_o, gpio_in_o, iso_en_o, direct_an_o;
   logic [NS-1:0]              periph_in_o;       // Pad level to slots
   logic [DEF_PINS-1:0]        afsel_o, den_o, analog_select_bit_o;                     // Readback
   logic [DEF_PINS*CODE_W-1:0] pctl_o;            // Code readback
   logic [DEF_PINS-1:0]        cfg_af, cfg_den, cfg_am;                     // Expected config
   logic [DEF_PINS*CODE_W-1:0] cfg_pc;            // Expected codes
   int                         err_total = 0;     // Mismatches
   int                         comparisons = 0;   // Checks made

   pin_function_mux #(.NUM_PINS(DEF_PINS), .NC(NUM_CODES)) pin_function_mux_i (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .afsel_wr_i(afsel_wr_i), .afsel_wdata_i(afsel_wdata_i),
      .den_wr_i(den_wr_i), .den_wdata_i(den_wdata_i), .analog_select_bit_wr_i(analog_select_bit_wr_i), .analog_select_bit_wdata_i(analog_select_bit_wdata_i),
      .pctl_wr_i(pctl_wr_i), .pctl_wdata_i(pctl_wdata_i), .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i),
      .periph_out_i(periph_out_i), .periph_oe_i(periph_oe_i), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
      .pad_oe_o(pad_oe_o), .gpio_in_o(gpio_in_o), .periph_in_o(periph_in_o), .iso_en_o(iso_en_o),
      .direct_an_o(direct_an_o), .afsel_o(afsel_o), .den_o(den_o), .analog_select_bit_o(analog_select_bit_o), .pctl_o(pctl_o));

   // ----------------------------------------------------------------------
   // Clock, watchdog and closing report
   // ----------------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   // Cuts a hang short and counts it as a mismatch
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      err_total++;
      results();
   end

   task automatic results();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Case-equal comparison of any result, zero-extended by the caller
   task automatic cmp(input logic [NS-1:0] got, input logic [NS-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // ----------------------------------------------------------------------
   // Shared helpers
   // ----------------------------------------------------------------------
   // Expected routing from the bench's own copy of the configuration
   task automatic check_route();
      logic [DEF_PINS-1:0] e_out, e_oe, e_gin, e_iso, e_dir;
      logic [NS-1:0]       e_pin;
      int                  s;
      {e_out, e_oe, e_gin, e_iso, e_dir} = '0;
      e_pin = '0;
      for (int p = 0; p < DEF_PINS; p++) begin
         s = p*NUM_CODES + int'(cfg_pc[CODE_W*p +: CODE_W]);
         if (cfg_af[p] && cfg_den[p]) begin
            // Alternate path only when a slot is chosen
            if (cfg_pc[CODE_W*p +: CODE_W] != 4'h0) begin
               e_out[p] = periph_out_i[s];
               e_oe[p]  = periph_oe_i[s];
               e_pin[s] = pad_in_i[p];
            end
         end else if (cfg_den[p]) begin
            e_out[p] = gpio_out_i[p];
            e_oe[p]  = gpio_oe_i[p];
         end else begin
            e_iso[p] = cfg_am[p];
            e_dir[p] = ~cfg_am[p];
         end
         if (cfg_den[p]) e_gin[p] = pad_in_i[p];
      end
      cmp(NS'(pad_oe_o), NS'(e_oe));
      cmp(NS'(pad_out_o), NS'(e_out));
      cmp(periph_in_o, e_pin);
      cmp(NS'(gpio_in_o), NS'(e_gin));
      cmp(NS'(iso_en_o), NS'(e_iso));
      cmp(NS'(direct_an_o), NS'(e_dir));
      cmp(NS'({afsel_o, den_o, analog_select_bit_o}), NS'({cfg_af, cfg_den, cfg_am}));
      cmp(NS'(pctl_o), NS'(cfg_pc));
   endtask

   // All four strobes in one cycle, then settle past the pad synchroniser
   task automatic write_cfg(input logic [23:0] af, input logic [23:0] dn, input logic [23:0] am,
                            input logic [95:0] pc);
      @(negedge clk_sys_i);
      {afsel_wr_i, den_wr_i, analog_select_bit_wr_i, pctl_wr_i} = 4'hf;
      {afsel_wdata_i, den_wdata_i, analog_select_bit_wdata_i, pctl_wdata_i} = {af, dn, am, pc};
      {cfg_af, cfg_den, cfg_am, cfg_pc} = {af, dn, am, pc};
      @(negedge clk_sys_i);
      {afsel_wr_i, den_wr_i, analog_select_bit_wr_i, pctl_wr_i} = 4'h0;
      repeat (7) @(negedge clk_sys_i);
      check_route();
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   // Reset held for a number of cycles, then default images and routing
   task automatic test_reset(input int cycles);
      @(negedge clk_sys_i);
      reset_i = 1'b1;
      repeat (cycles) @(negedge clk_sys_i);
      reset_i = 1'b0;
      {cfg_af, cfg_den, cfg_am, cfg_pc} = {24'h0f0000, DEN_RST, 24'h000000, 96'h0};
      for (int p = 0; p < DEF_PINS; p++) begin
         if (p < 6 || p == 10 || p == 11) cfg_pc[4*p +: 4] = 4'h1;
         if (p >= 16 && p < 20) cfg_pc[4*p +: 4] = 4'h3;
      end
      repeat (7) @(negedge clk_sys_i);
      check_route();
   endtask

   // Every code 0..15 appears across the pins in alternate mode
   task automatic test_alt_codes();
      logic [95:0] pc;
      for (int p = 0; p < DEF_PINS; p++) pc[4*p +: 4] = 4'(p % 16);
      pad_in_i = 24'h3ca569;
      write_cfg(24'hffffff, 24'hffffff, 24'h000000, pc);
      pc = {pc[47:0], pc[95:48]};
      write_cfg(24'hffffff, 24'hffffff, 24'h000000, pc);
   endtask

   // Select set without digital enable, and GPIO with codes ignored
   task automatic test_modes();
      write_cfg(24'hffffff, 24'h00ff00, 24'h0f0f0f, {24{4'h2}});
      write_cfg(24'h0000ff, 24'hffffff, 24'h000000, {24{4'h5}});
      @(negedge clk_sys_i);
      gpio_out_i = ~gpio_out_i;
      pad_in_i   = ~pad_in_i;
      repeat (7) @(negedge clk_sys_i);
      check_route();
      write_cfg(24'h5a5a5a, 24'h000000, 24'ha5a5a5, {24{4'h7}});
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      reset_i = 1'b1;
      {afsel_wr_i, den_wr_i, analog_select_bit_wr_i, pctl_wr_i} = 4'h0;
      {afsel_wdata_i, den_wdata_i, analog_select_bit_wdata_i, pctl_wdata_i} = '0;
      gpio_out_i   = 24'h5ac396;
      gpio_oe_i    = 24'hf0f00f;
      pad_in_i     = 24'h000000;
      periph_out_i = {16{24'h6db249}};
      periph_oe_i  = {16{24'h935ea7}};
      test_reset(8);
      test_alt_codes();
      test_modes();
      test_reset(2);
      results();
   end
endmodule
